// ==== src/csq_pkg.sv ====
// package: constants for the conversion sample queue
package csq_pkg;
	localparam int DEPTH = 12;
	localparam int ENTRY_W = 56;
	localparam int DATA_W = 24;
	localparam int PTR_W = 4;
	localparam int LVL_W = 5;
	// register offsets on the plain port
	localparam logic [3:0] OFS_FORMAT = 4'h0;
	localparam logic [3:0] OFS_THRESH = 4'h1;
	localparam logic [3:0] OFS_CHAN1 = 4'h2;
	localparam logic [3:0] OFS_CHAN2 = 4'h3;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_IRQ_STAT = 4'h5;
	localparam logic [3:0] OFS_IRQ_MASK = 4'h6;
	localparam logic [3:0] OFS_ENTRY_HI = 4'h7;
	localparam logic [3:0] OFS_ENTRY_LO = 4'h8;
	// field positions
	localparam int FMT_EN_BIT = 0;
	localparam int FMT_INTEN_BIT = 1;
	localparam int FMT_CFG_LSB = 2;
	localparam int FMT_GSEL_LSB = 5;
	localparam int CH_PD_BIT = 7;
	localparam int ST_EMPTY_BIT = 7;
	localparam int ST_FULL_BIT = 8;
	localparam int ST_ERR_BIT = 10;
	// frame format codes
	localparam logic [2:0] FRAME_SINGLE = 3'h0;
	localparam logic [2:0] FRAME_DUAL = 3'h1;
	// reset values
	localparam logic [7:0] FORMAT_RST = 8'h00;
	localparam logic [4:0] THRESH_RST = 5'h01;
	localparam logic [7:0] CHAN_RST = 8'h00;
	localparam logic [31:0] INVALID_WORD = 32'hffffffff;
	// interrupt pulse: least 4 us, rounded up to whole cycles
	localparam int CLK_HZ = 10000000;
	localparam int IRQ_PULSE_NS = 4000;
	localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam logic [5:0] IRQ_PULSE_CNT = 6'(IRQ_PULSE_CYC);
	// event bits
	localparam int EV_THRESH = 0;
	localparam int EV_ERROR = 1;
	localparam int EV_OVERFLOW = 2;
endpackage

// ==== src/csq_queue.sv ====
// module: conversion sample queue with packing, threshold alert and read-out
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/10ps
module csq_queue
	import csq_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RESET,
	// register port
	input wire logic [3:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WRITE,
	input wire logic REG_READ,
	output logic [31:0] REG_RDATA,
	// conversion results from the converter core
	input wire logic CONV_VALID,
	input wire logic [DATA_W-1:0] CONV_CH1,
	input wire logic [DATA_W-1:0] CONV_CH2,
	input wire logic [2:0] BO_CH1,
	input wire logic [2:0] BO_CH2,
	input wire logic [3:0] GPIO_STATE,
	// read-queue command from the serial command decoder
	input wire logic READ_QUEUE_COMMAND,
	input wire logic COMMAND_CRC_OK,
	output logic ENTRY_VALID,
	output logic [ENTRY_W-1:0] ENTRY_DATA,
	// alert lines
	output logic DATA_READY_N,
	output logic QUEUE_INTERRUPT,
	output logic IRQ
);
	logic [ENTRY_W-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [LVL_W-1:0] queue_fill_level;
	logic [7:0] queue_format_config;
	logic [4:0] queue_threshold_config;
	logic [7:0] channel_one_settings;
	logic [7:0] channel_two_settings;
	logic [2:0] irq_stat_reg;
	logic [2:0] irq_mask_reg;
	logic [5:0] pulse_cnt_reg;
	logic half_reg;
	logic [2:0] bo_first_reg;
	logic gpio_first_reg;
	logic [DATA_W-1:0] data_first_reg;
	logic [ENTRY_W-1:0] last_read_reg;
	logic at_thresh_reg;
	logic reached;
	logic [31:0] status_word;

	// notes on behaviour
	// entries enter only while the queue is enabled;
	// a conversion pulse outside an enabled format is ignored
	// single-channel format holds the first half in a side register
	// and writes one entry on every second conversion pulse
	// leaving the single format or disabling clears the half flag,
	// so a stale first half never pairs with a later sample
	// the active channel is channel one unless it is powered down;
	// with both powered down channel two is still chosen
	// dual format writes one entry per conversion pulse
	// and carries the selected gpio plus its neighbour
	// a full queue keeps its oldest entries and drops the new one,
	// raising the overflow event; a pop in the same cycle makes room
	// pointers wrap at the queue depth, not at their binary range
	// the fill level is the only count of stored entries;
	// full and empty are decoded from it, never from the pointers
	// read-queue commands with a failed check are ignored completely:
	// no valid pulse, no data change, no pointer movement
	// an accepted command on a disabled or empty queue answers
	// with an all-ones entry and leaves the pointers alone
	// the answered entry stays on the entry port until the next answer
	// and a popped entry is also kept for the two entry read-back registers
	// data ready follows the level: low while enabled and at threshold
	// the gpio interrupt is a stretched pulse started by a rising
	// crossing of the threshold; a new crossing restarts the stretch
	// the threshold event is edge based so a queue sitting above the
	// threshold raises it once, not every cycle
	// the pointer error is a level: it sets its sticky bit every cycle
	// while the queue is disabled and its read and write pointers differ
	// sticky status bits clear on a read of the interrupt status register,
	// but an event in the same cycle as that read is kept
	// the level interrupt lags the sticky bits by one cycle
	// register read data stand for one cycle only, zero otherwise

	// hazards
	// a format register write mid-pair that leaves the enabled single format drops the pending half
	// changing the channel power-down mid-pair mixes channels in one entry
	// lowering the threshold below the level gives one immediate event
	// a burst of more commands than stored entries reads all-ones tails

	// limitations
	// the queue has no bypass: an entry is readable one cycle after
	// the conversion pulse that completes it
	// the entry port has no back-pressure; the controller must take
	// every answer in the cycle its valid pulse stands
	// conversion inputs and the command pulse come from logic on
	// this clock, so they are used without synchronisers
	// the interrupt stretch length is fixed in the package and
	// assumes the nominal clock rate
	// the mask only gates the level interrupt, not the sticky bits
	// reset clears pointers and level but not the storage array;
	// stale words there are never read because the level is zero
	// unmapped register indices read zero and ignore writes
	// format codes other than the two known ones store nothing
	// the error bit in the status word is live, not sticky
	// fill level, full and empty in the status word are live too
	// the side register for the first half is not reset; it is always
	// written before the half flag lets it into an entry

	// field views
	logic q_en, int_en, ch1_on, ch2_on, gpio_bit, full, empty;
	logic push, pop, rd_ok, ev_thresh, ev_err, ev_ovf;
	logic [2:0] frame_cfg;
	logic [1:0] gpio_sel;
	logic [2:0] bo_act;
	logic [DATA_W-1:0] data_act;
	logic [ENTRY_W-1:0] entry_new;

	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 4'h1;
	endfunction

	assign q_en = queue_format_config[FMT_EN_BIT];
	assign int_en = queue_format_config[FMT_INTEN_BIT];
	assign frame_cfg = queue_format_config[FMT_CFG_LSB +: 3];
	assign gpio_sel = queue_format_config[FMT_GSEL_LSB +: 2];
	assign ch1_on = ~channel_one_settings[CH_PD_BIT];
	assign ch2_on = ~channel_two_settings[CH_PD_BIT];
	assign gpio_bit = GPIO_STATE[gpio_sel];
	assign bo_act = ch1_on ? BO_CH1 : BO_CH2;
	assign data_act = ch1_on ? CONV_CH1 : CONV_CH2;
	assign full = (queue_fill_level == LVL_W'(DEPTH));
	assign empty = (queue_fill_level == '0);
	// fill level at or above the programmed alert count
	assign reached = (queue_fill_level >= queue_threshold_config);

	// status word: level, empty, full, pointer error
	always_comb begin
		status_word = '0;
		status_word[LVL_W-1:0] = queue_fill_level;
		status_word[ST_EMPTY_BIT] = empty;
		status_word[ST_FULL_BIT] = full;
		status_word[ST_ERR_BIT] = ev_err;
	end

	// entry packing per frame format
	always_comb begin
		entry_new = '0;
		push = 1'b0;
		if (q_en && CONV_VALID) begin
			if (frame_cfg == FRAME_SINGLE) begin
				push = half_reg;
				entry_new = {bo_first_reg, bo_act, gpio_first_reg, gpio_bit,
					data_first_reg, data_act};
			end else if (frame_cfg == FRAME_DUAL) begin
				push = 1'b1;
				entry_new = {BO_CH1, BO_CH2[1:0], 1'b0, GPIO_STATE[gpio_sel],
					GPIO_STATE[gpio_sel ^ 2'h1], CONV_CH1, CONV_CH2};
			end
		end
	end

	assign rd_ok = READ_QUEUE_COMMAND && COMMAND_CRC_OK;
	assign pop = rd_ok && q_en && !empty;
	assign ev_ovf = push && full && !pop;
	assign ev_err = !q_en && (rd_ptr_reg != wr_ptr_reg);
	assign ev_thresh = reached && !at_thresh_reg;

	// first half of a single-channel pair
	always_ff @(posedge CLOCK) begin
		if (RESET || !q_en || frame_cfg != FRAME_SINGLE) begin
			half_reg <= 1'b0;
		end else if (CONV_VALID) begin
			half_reg <= ~half_reg;
			if (!half_reg) begin
				bo_first_reg <= bo_act;
				gpio_first_reg <= gpio_bit;
				data_first_reg <= data_act;
			end
		end
	end

	// storage array, entry dropped when full
	always_ff @(posedge CLOCK) begin
		if (push && (!full || pop)) begin
			mem[wr_ptr_reg] <= entry_new;
		end
	end

	// write pointer
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			wr_ptr_reg <= '0;
		end else if (push && (!full || pop)) begin
			wr_ptr_reg <= ptr_inc(wr_ptr_reg);
		end
	end

	// read pointer, untouched while disabled
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			rd_ptr_reg <= '0;
		end else if (pop) begin
			rd_ptr_reg <= ptr_inc(rd_ptr_reg);
		end
	end

	// fill level
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			queue_fill_level <= '0;
		end else if (push && !full && !pop) begin
			queue_fill_level <= queue_fill_level + 5'h1;
		end else if (pop && !(push)) begin
			queue_fill_level <= queue_fill_level - 5'h1;
		end
	end

	// entry output, no CRC appended
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			ENTRY_VALID <= 1'b0;
			ENTRY_DATA <= '0;
			last_read_reg <= '0;
		end else begin
			ENTRY_VALID <= rd_ok;
			if (pop) begin
				ENTRY_DATA <= mem[rd_ptr_reg];
				last_read_reg <= mem[rd_ptr_reg];
			end else if (rd_ok) begin
				ENTRY_DATA <= {INVALID_WORD[23:0], INVALID_WORD};
			end
		end
	end

	// threshold edge tracking
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			at_thresh_reg <= 1'b0;
		end else begin
			at_thresh_reg <= reached;
		end
	end

	// data ready low while threshold reached
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			DATA_READY_N <= 1'b1;
		end else begin
			DATA_READY_N <= !(q_en && reached);
		end
	end

	// gpio interrupt pulse stretcher
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			pulse_cnt_reg <= '0;
			QUEUE_INTERRUPT <= 1'b0;
		end else if (int_en && q_en && ev_thresh) begin
			pulse_cnt_reg <= IRQ_PULSE_CNT - 6'h1;
			QUEUE_INTERRUPT <= 1'b1;
		end else if (pulse_cnt_reg != '0) begin
			pulse_cnt_reg <= pulse_cnt_reg - 6'h1;
		end else begin
			QUEUE_INTERRUPT <= 1'b0;
		end
	end

	// configuration registers
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			queue_format_config <= FORMAT_RST;
			queue_threshold_config <= THRESH_RST;
			channel_one_settings <= CHAN_RST;
			channel_two_settings <= CHAN_RST;
			irq_mask_reg <= '0;
		end else if (REG_WRITE) begin
			unique case (REG_ADDR)
				OFS_FORMAT: queue_format_config <= REG_WDATA[7:0];
				OFS_THRESH: queue_threshold_config <= REG_WDATA[4:0];
				OFS_CHAN1: channel_one_settings <= REG_WDATA[7:0];
				OFS_CHAN2: channel_two_settings <= REG_WDATA[7:0];
				OFS_IRQ_MASK: irq_mask_reg <= REG_WDATA[2:0];
				default: ;
			endcase
		end
	end

	// sticky status, set wins over read clear
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			irq_stat_reg <= '0;
		end else begin
			irq_stat_reg <= ((REG_READ && REG_ADDR == OFS_IRQ_STAT) ? 3'h0 : irq_stat_reg)
				| {ev_ovf, ev_err, ev_thresh && q_en};
		end
	end

	// interrupt level output
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// read data one cycle after strobe
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			REG_RDATA <= '0;
		end else if (REG_READ) begin
			unique case (REG_ADDR)
				OFS_FORMAT: REG_RDATA <= {24'h0, queue_format_config};
				OFS_THRESH: REG_RDATA <= {27'h0, queue_threshold_config};
				OFS_CHAN1: REG_RDATA <= {24'h0, channel_one_settings};
				OFS_CHAN2: REG_RDATA <= {24'h0, channel_two_settings};
				OFS_STATUS: REG_RDATA <= status_word;
				OFS_IRQ_STAT: REG_RDATA <= {29'h0, irq_stat_reg};
				OFS_IRQ_MASK: REG_RDATA <= {29'h0, irq_mask_reg};
				OFS_ENTRY_HI: REG_RDATA <= {8'h0, last_read_reg[55:32]};
				OFS_ENTRY_LO: REG_RDATA <= last_read_reg[31:0];
				default: REG_RDATA <= '0;
			endcase
		end else begin
			REG_RDATA <= '0;
		end
	end
endmodule

// ==== testbench/csq_checker.sv ====
// checker: port timing of the sample queue
`timescale 1ns/10ps
module csq_checker
	import csq_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic REG_READ,
	input wire logic [31:0] REG_RDATA,
	input wire logic READ_QUEUE_COMMAND,
	input wire logic COMMAND_CRC_OK,
	input wire logic ENTRY_VALID,
	input wire logic [ENTRY_W-1:0] ENTRY_DATA,
	input wire logic DATA_READY_N,
	input wire logic QUEUE_INTERRUPT,
	input wire logic IRQ
);
	logic [5:0] hi_cnt;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RESET);
	// cycles the queue interrupt has stood high
	always_ff @(posedge CLOCK) begin
		if (RESET || !QUEUE_INTERRUPT) hi_cnt <= 6'h00;
		else hi_cnt <= hi_cnt + 6'(hi_cnt != 6'h3f);
	end
	a_entry_needs_cmd: assert property (ENTRY_VALID |->
		$past(READ_QUEUE_COMMAND && COMMAND_CRC_OK)) else $error("stray entry");
	a_bad_crc_drop: assert property (READ_QUEUE_COMMAND && !COMMAND_CRC_OK |=>
		!ENTRY_VALID) else $error("bad crc answered");
	a_cmd_answered: assert property (READ_QUEUE_COMMAND && COMMAND_CRC_OK |=>
		ENTRY_VALID) else $error("no answer");
	a_data_holds: assert property ($changed(ENTRY_DATA) |-> ENTRY_VALID)
		else $error("data moved");
	a_pulse_rise_hold: assert property ($rose(QUEUE_INTERRUPT) |=>
		QUEUE_INTERRUPT [*8]) else $error("short pulse");
	a_pulse_min_len: assert property ($fell(QUEUE_INTERRUPT) |->
		hi_cnt >= IRQ_PULSE_CNT) else $error("pulse too short");
	a_rdata_idle: assert property (!REG_READ |=> REG_RDATA == 32'h0)
		else $error("rdata not idle");
	a_reset_levels: assert property (disable iff (1'b0) RESET |=>
		DATA_READY_N && !ENTRY_VALID && !QUEUE_INTERRUPT && !IRQ) else $error("reset levels");
endmodule

bind csq_queue csq_checker i_csq_checker (
	.CLOCK(CLOCK),
	.RESET(RESET),
	.REG_READ(REG_READ),
	.REG_RDATA(REG_RDATA),
	.READ_QUEUE_COMMAND(READ_QUEUE_COMMAND),
	.COMMAND_CRC_OK(COMMAND_CRC_OK),
	.ENTRY_VALID(ENTRY_VALID),
	.ENTRY_DATA(ENTRY_DATA),
	.DATA_READY_N(DATA_READY_N),
	.QUEUE_INTERRUPT(QUEUE_INTERRUPT),
	.IRQ(IRQ)
);

// ==== testbench/csq_mcu_model.sv ====
// model: controller issuing read-queue command bursts
`timescale 1ns/10ps
module csq_mcu_model (
	input wire logic CLOCK,
	input wire logic start,
	input wire logic [3:0] count,
	input wire logic crc_good,
	output logic READ_QUEUE_COMMAND,
	output logic COMMAND_CRC_OK
);
	logic [3:0] left_reg = 4'h0;
	logic crc_reg = 1'b1;
	// burst length clamped to the queue depth
	always @(posedge CLOCK) begin
		if (start) left_reg <= (count > 4'hc) ? 4'hc : count;
		else if (left_reg != 4'h0) left_reg <= left_reg - 4'h1;
		if (start) crc_reg <= crc_good;
	end
	// commands only on request, never continuous read; idle crc line inverted
	assign READ_QUEUE_COMMAND = left_reg != 4'h0;
	assign COMMAND_CRC_OK = (left_reg != 4'h0) ? crc_reg : ~crc_reg;
endmodule

// ==== testbench/tb_csq_queue.sv ====
// testbench: register, conversion and read-out sequences
`timescale 1ns/10ps
module tb_csq_queue
	import csq_pkg::*;
;
	logic CLOCK, RESET = 1'b1, REG_WRITE = 1'b0, REG_READ = 1'b0, CONV_VALID = 1'b0;
	logic start = 1'b0, crc_good = 1'b0, ENTRY_VALID, DATA_READY_N, QUEUE_INTERRUPT, IRQ;
	logic READ_QUEUE_COMMAND, COMMAND_CRC_OK;
	logic [3:0] REG_ADDR = 4'h0, GPIO_STATE = 4'h0, count = 4'h0;
	logic [31:0] REG_WDATA = 32'h0, REG_RDATA;
	logic [23:0] CONV_CH1 = 24'h0, CONV_CH2 = 24'h0;
	logic [2:0] BO_CH1 = 3'h0, BO_CH2 = 3'h0;
	logic [55:0] ENTRY_DATA, x, got[$];
	int mismatches, checks;
	csq_queue i_csq_queue (
		.CLOCK(CLOCK),
		.RESET(RESET),
		.REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA),
		.REG_WRITE(REG_WRITE),
		.REG_READ(REG_READ),
		.REG_RDATA(REG_RDATA),
		.CONV_VALID(CONV_VALID),
		.CONV_CH1(CONV_CH1),
		.CONV_CH2(CONV_CH2),
		.BO_CH1(BO_CH1),
		.BO_CH2(BO_CH2),
		.GPIO_STATE(GPIO_STATE),
		.READ_QUEUE_COMMAND(READ_QUEUE_COMMAND),
		.COMMAND_CRC_OK(COMMAND_CRC_OK),
		.ENTRY_VALID(ENTRY_VALID),
		.ENTRY_DATA(ENTRY_DATA),
		.DATA_READY_N(DATA_READY_N),
		.QUEUE_INTERRUPT(QUEUE_INTERRUPT),
		.IRQ(IRQ)
	);
	csq_mcu_model i_csq_mcu_model (
		.CLOCK(CLOCK),
		.start(start),
		.count(count),
		.crc_good(crc_good),
		.READ_QUEUE_COMMAND(READ_QUEUE_COMMAND),
		.COMMAND_CRC_OK(COMMAND_CRC_OK)
	);
	// clock and entry capture
	initial begin
		CLOCK = 1'b0;
		forever #50 CLOCK = ~CLOCK;
	end
	always @(posedge CLOCK) if (ENTRY_VALID === 1'b1) got.push_back(ENTRY_DATA);
	task chk(input string n, input logic [55:0] e, input logic [55:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WRITE <= 1'b1;
		@(posedge CLOCK);
		REG_WRITE <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge CLOCK);
		REG_ADDR <= a;
		REG_READ <= 1'b1;
		@(posedge CLOCK);
		REG_READ <= 1'b0;
		#1;
		chk("rdata", 56'(e), 56'(REG_RDATA));
	endtask
	task conv(input logic [7:0] k);
		@(posedge CLOCK);
		CONV_CH1 <= {16'ha000, k};
		CONV_CH2 <= {16'hb000, k};
		BO_CH1 <= k[2:0];
		BO_CH2 <= ~k[2:0];
		GPIO_STATE <= k[3:0];
		CONV_VALID <= 1'b1;
		@(posedge CLOCK);
		CONV_VALID <= 1'b0;
	endtask
	task mcu(input logic [3:0] n, input logic c);
		@(posedge CLOCK);
		start <= 1'b1;
		count <= n;
		crc_good <= c;
		@(posedge CLOCK);
		start <= 1'b0;
		repeat (16) @(posedge CLOCK);
	endtask
	// expected entries, gpio selector 2
	function automatic logic [55:0] one(input logic [7:0] k, input logic c2);
		logic [7:0] j;
		j = k + 8'h1;
		if (c2) return {~k[2:0], ~j[2:0], k[2], j[2], 16'hb000, k, 16'hb000, j};
		return {k[2:0], j[2:0], k[2], j[2], 16'ha000, k, 16'ha000, j};
	endfunction
	function automatic logic [55:0] two(input logic [7:0] k);
		return {k[2:0], ~k[1:0], 1'b0, k[2], k[3], 16'ha000, k, 16'hb000, k};
	endfunction
	// main sequence
	initial begin
		repeat (20) @(posedge CLOCK);
		RESET <= 1'b0;
		#1;
		chk("ready", 56'h1, 56'(DATA_READY_N));
		rd(OFS_THRESH, 32'h1);
		rd(4'hf, 32'h0);
		mcu(4'h1, 1'b1);
		chk("off", {56{1'b1}}, got.pop_front());
		rd(OFS_STATUS, 32'h80);
		wr(OFS_IRQ_MASK, 32'h5);
		wr(OFS_THRESH, 32'h2);
		wr(OFS_FORMAT, 32'h43);
		for (int i = 0; i < 4; i++) conv(8'(i));
		repeat (3) @(posedge CLOCK);
		#1;
		chk("alert", 56'h3, 56'({DATA_READY_N, QUEUE_INTERRUPT, IRQ}));
		rd(OFS_STATUS, 32'h2);
		rd(OFS_IRQ_STAT, 32'h1);
		rd(OFS_IRQ_STAT, 32'h0);
		mcu(4'h1, 1'b0);
		chk("drop", 56'h0, 56'(got.size()));
		mcu(4'h2, 1'b1);
		for (int i = 0; i < 2; i++) chk("one", one(8'(2 * i), 1'b0), got.pop_front());
		wr(OFS_CHAN1, 32'h80);
		conv(8'h4);
		conv(8'h5);
		mcu(4'h1, 1'b1);
		x = one(8'h4, 1'b1);
		chk("ch2", x, got.pop_front());
		rd(OFS_ENTRY_HI, {8'h0, x[55:32]});
		rd(OFS_ENTRY_LO, x[31:0]);
		wr(OFS_CHAN1, 32'h0);
		wr(OFS_FORMAT, 32'h47);
		for (int i = 6; i < 19; i++) conv(8'(i));
		rd(OFS_STATUS, 32'h10c);
		rd(OFS_IRQ_STAT, 32'h5);
		mcu(4'h1, 1'b1);
		chk("two", two(8'h6), got.pop_front());
		wr(OFS_FORMAT, 32'h46);
		mcu(4'h1, 1'b1);
		chk("off", {56{1'b1}}, got.pop_front());
		rd(OFS_STATUS, 32'h40b);
		chk("mask", 56'h0, 56'(IRQ));
		rd(OFS_IRQ_STAT, 32'h2);
		wr(OFS_FORMAT, 32'h47);
		mcu(4'hf, 1'b1);
		for (int i = 0; i < 11; i++) chk("two", two(8'(7 + i)), got.pop_front());
		chk("tail", {56{1'b1}}, got.pop_front());
		rd(OFS_STATUS, 32'h80);
		final_report;
	end
	// watchdog
	initial begin
		#500000;
		mismatches++;
		final_report;
	end
endmodule
